/* sztc_core.sv */
// Operation
// - Zero accepted only inside percent window
// - Zero from key, input, PLC, serial Z
// - Net equals gross minus stored tare
// - Tare key ignored when pushbutton tare off
// - Pushbutton tare stores gross, enters net
// - Motion waits three seconds for stability
// - Motion timeout aborts, error, tare kept
// - Gross at or below zero: too small
// - Preset above capacity rejected, motion ignored
// - Keypad preset refused when keyboard tare off
// - Over capacity or under zero blocks preset
// - Preset rounded to nearest display interval
// - New preset overwrites previous tare
// - Twenty-five records: description, tare, totals
// - Totalization adds weight, bumps counter
// - Sign correction off: net may be negative
// - Sign correction on: swap, net positive
// - Memory marker shown under sign correction
// - Armed auto tare fires above threshold
// - Re-arm below reset, reset below threshold
// - Motion check delays re-arm until stable
// - Auto tare waits three seconds for stability
module sztc_core #(
  parameter int unsigned WAIT_CYC = sztc_pkg::MOTION_WAIT_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire sztc_pkg::sztc_scale_s scale_in,
  input  wire logic                 zero_key,
  input  wire logic                 tare_key,
  input  wire logic                 zero_din,
  input  wire logic                 plc_zero,
  input  wire logic                 plc_tare,
  input  wire logic                 plc_preset_valid,
  input  wire logic [31:0]          plc_preset_value,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  output sztc_pkg::sztc_weight_s    weight_out,
  output logic                      net_mode,
  output logic                      mem_marker,
  output logic                      busy,
  output logic                      at_armed,
  output sztc_pkg::sztc_evt_s       tare_evt
);
  import sztc_pkg::*;

  function automatic logic [31:0] round_iv(input logic [31:0] v,
                                           input logic [31:0] d);
    logic [31:0] rem;
    logic [31:0] res;
    rem = 32'h0;
    res = v;
    if (d != 32'h0) begin
      rem = v % d;
      res = v - rem;
      if ({rem, 1'b0} >= {1'b0, d}) begin
        res = res + d;
      end
    end
    return res;
  endfunction

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [6:0]         zrange_reg;
  logic [31:0]        cap_reg;
  logic [31:0]        interval_reg;
  logic signed [31:0] at_thresh_reg;
  logic signed [31:0] at_reset_reg;
  logic signed [31:0] init_zero_reg;
  logic [4:0]         rec_sel_reg;
  logic [3:0]         cmd_reg;
  logic [5:0]         err_reg;
  logic signed [31:0] tare_reg;
  logic signed [31:0] zero_ofs_reg;
  logic [4:0]         cur_rec_reg;
  logic               cur_rec_ok_reg;
  sztc_state_e        state_reg;
  logic [31:0]        wait_cnt_reg;
  logic [2:0]         zk_sync;
  logic [2:0]         tk_sync;
  logic [2:0]         zd_sync;

  logic signed [31:0] rec_tare  [NUM_REC];
  logic [31:0]        rec_total [NUM_REC];
  logic [15:0]        rec_count [NUM_REC];
  logic [31:0]        rec_desc  [NUM_REC][DESC_WORDS];

  logic               wr_en;
  logic               rd_setup;
  logic               sel_ok;
  logic signed [31:0] gross;
  logic signed [31:0] disp_gross;
  logic signed [31:0] disp_tare;
  logic signed [31:0] disp_net;
  logic               zero_req;
  logic               tare_req;
  logic               kb_req;
  logic               preset_req;
  logic [31:0]        preset_raw;
  logic [31:0]        preset_rnd;
  logic               zero_in_range;
  logic signed [32:0] zdev;
  logic [32:0]        zdev_abs;
  logic               wait_done;
  logic               pb_fire;
  logic               at_fire;
  logic               rearm;
  logic               do_trans;
  sztc_evt_s          evt_next;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign sel_ok   = rec_sel_reg <= REC_LAST;
  assign gross    = scale_in.raw - zero_ofs_reg;

  // Sign correction swaps roles only in net mode with tare above gross
  always_comb begin
    disp_gross = gross;
    disp_tare  = net_mode ? tare_reg : 32'sh0;
    if (ctrl_reg[CTRL_NSC_EN] && net_mode && tare_reg > gross) begin
      disp_gross = tare_reg;
      disp_tare  = gross;
    end
    disp_net = disp_gross - disp_tare;
  end

  // Front panel keys and discrete input are asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zk_sync <= 3'h0;
      tk_sync <= 3'h0;
      zd_sync <= 3'h0;
    end else begin
      zk_sync <= {zk_sync[1:0], zero_key};
      tk_sync <= {tk_sync[1:0], tare_key};
      zd_sync <= {zd_sync[1:0], zero_din};
    end
  end

  always_comb begin
    zero_req = (zk_sync[1] && !zk_sync[2]) || (zd_sync[1] && !zd_sync[2])
               || plc_zero || (rx_valid && rx_data == ZERO_CHAR)
               || cmd_reg[CMD_ZERO];
    tare_req = ((tk_sync[1] && !tk_sync[2]) || plc_tare
                || cmd_reg[CMD_TARE]) && ctrl_reg[CTRL_PB_EN];
    kb_req   = wr_en && paddr == OFS_KB_PRESET && ctrl_reg[CTRL_KB_EN];
    preset_req = kb_req || plc_preset_valid
                 || (cmd_reg[CMD_RECALL] && sel_ok);
    if (kb_req) begin
      preset_raw = pwdata;
    end else if (plc_preset_valid) begin
      preset_raw = plc_preset_value;
    end else begin
      preset_raw = sel_ok ? rec_tare[rec_sel_reg] : 32'h0;
    end
    preset_rnd = round_iv(preset_raw, interval_reg);
    zdev = {scale_in.raw[31], scale_in.raw}
           - (ctrl_reg[CTRL_PUZ_EN] ? {init_zero_reg[31], init_zero_reg}
                                    : 33'sh0);
    zdev_abs = zdev[32] ? 33'(-zdev) : 33'(zdev);
    zero_in_range = 64'(zdev_abs) * 64'(PCT_FULL)
                    <= 64'(cap_reg) * 64'(zrange_reg);
    wait_done = wait_cnt_reg >= WAIT_CYC - 1;
    pb_fire = tare_req && gross > 32'sh0 && !scale_in.motion;
    at_fire = ctrl_reg[CTRL_AT_EN] && at_armed && gross > at_thresh_reg;
    rearm = !at_armed && at_reset_reg < at_thresh_reg
            && gross < at_reset_reg
            && !(ctrl_reg[CTRL_AT_MCHK] && scale_in.motion);
    do_trans = cmd_reg[CMD_TRANS] && ctrl_reg[CTRL_TOT_EN] && cur_rec_ok_reg;
  end

  // Request sequencer; waits block any new zero or tare request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      wait_cnt_reg   <= 32'h0;
      tare_reg       <= 32'sh0;
      net_mode       <= 1'b0;
      zero_ofs_reg   <= 32'sh0;
      at_armed       <= 1'b1;
      cur_rec_reg    <= 5'h0;
      cur_rec_ok_reg <= 1'b0;
      evt_next       <= '0;
    end else begin
      evt_next <= '0;
      if (rearm) begin
        at_armed <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          wait_cnt_reg <= 32'h0;
          if (zero_req) begin
            if (zero_in_range) begin
              zero_ofs_reg <= scale_in.raw;
            end else begin
              evt_next.zero_fail <= 1'b1;
            end
          end else if (tare_req) begin
            if (gross <= 32'sh0) begin
              evt_next.too_small <= 1'b1;
            end else if (scale_in.motion) begin
              state_reg <= ST_WAIT_PB;
            end else begin
              tare_reg <= gross;
              net_mode <= 1'b1;
              cur_rec_ok_reg <= 1'b0;
            end
          end else if (preset_req) begin
            if (scale_in.over_cap) begin
              evt_next.over_cap <= 1'b1;
            end else if (scale_in.under_zero) begin
              evt_next.too_small <= 1'b1;
            end else if (preset_rnd > cap_reg) begin
              evt_next.out_of_range <= 1'b1;
            end else begin
              tare_reg <= $signed(preset_rnd);
              net_mode <= 1'b1;
              cur_rec_ok_reg <= cmd_reg[CMD_RECALL] && !kb_req
                                && !plc_preset_valid;
              cur_rec_reg <= rec_sel_reg;
            end
          end else if (at_fire) begin
            at_armed <= 1'b0;
            if (scale_in.motion) begin
              state_reg <= ST_WAIT_AT;
            end else begin
              tare_reg <= gross;
              net_mode <= 1'b1;
              cur_rec_ok_reg <= 1'b0;
            end
          end
        end
        ST_WAIT_PB, ST_WAIT_AT: begin
          if (!scale_in.motion) begin
            state_reg <= ST_IDLE;
            tare_reg  <= gross;
            net_mode  <= 1'b1;
            cur_rec_ok_reg <= 1'b0;
          end else if (wait_done) begin
            state_reg <= ST_IDLE;
            if (state_reg == ST_WAIT_PB) begin
              evt_next.motion_fail <= 1'b1;
            end else begin
              evt_next.at_motion_fail <= 1'b1;
            end
          end else begin
            // Count only while still waiting, so it never passes the limit
            wait_cnt_reg <= wait_cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Tare records: 25 entries, no reset on the storage to keep it as RAM
  always_ff @(posedge pclk) begin
    if (wr_en && sel_ok && paddr == OFS_REC_TARE) begin
      rec_tare[rec_sel_reg] <= pwdata;
    end
    for (int i = 0; i < DESC_WORDS; i++) begin
      if (wr_en && sel_ok && paddr == OFS_REC_DESC + 8'(4 * i)) begin
        rec_desc[rec_sel_reg][i] <= pwdata;
      end
    end
    if (wr_en && sel_ok && paddr == OFS_REC_TOTAL) begin
      rec_total[rec_sel_reg] <= WORD_RST;
      rec_count[rec_sel_reg] <= 16'h0;
    end else if (do_trans) begin
      rec_total[cur_rec_reg] <= rec_total[cur_rec_reg]
        + (ctrl_reg[CTRL_TOT_NET] ? disp_net : disp_gross);
      rec_count[cur_rec_reg] <= rec_count[cur_rec_reg] + 16'h1;
    end
  end

  // Configuration and command registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= CTRL_RST;
      zrange_reg    <= ZRANGE_RST;
      cap_reg       <= CAP_RST;
      interval_reg  <= INTERVAL_RST;
      at_thresh_reg <= WORD_RST;
      at_reset_reg  <= WORD_RST;
      init_zero_reg <= WORD_RST;
      rec_sel_reg   <= 5'h0;
      cmd_reg       <= 4'h0;
    end else begin
      cmd_reg <= 4'h0;
      if (wr_en) begin
        if (paddr == OFS_CTRL) begin
          ctrl_reg <= pwdata[CTRL_W-1:0];
        end else if (paddr == OFS_ZRANGE) begin
          // Window saturates at full capacity
          zrange_reg <= (pwdata[6:0] > PCT_FULL) ? PCT_FULL : pwdata[6:0];
        end else if (paddr == OFS_CAPACITY) begin
          cap_reg <= pwdata;
        end else if (paddr == OFS_INTERVAL) begin
          interval_reg <= pwdata;
        end else if (paddr == OFS_AT_THRESH) begin
          at_thresh_reg <= pwdata;
        end else if (paddr == OFS_AT_RESET) begin
          at_reset_reg <= pwdata;
        end else if (paddr == OFS_INIT_ZERO) begin
          init_zero_reg <= pwdata;
        end else if (paddr == OFS_REC_SEL) begin
          rec_sel_reg <= pwdata[4:0];
        end else if (paddr == OFS_CMD) begin
          cmd_reg <= pwdata[3:0];
        end
      end
    end
  end

  // Sticky error flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 6'h0;
    end else begin
      err_reg <= (err_reg & ~((wr_en && paddr == OFS_ERR) ? pwdata[5:0]
                                                          : 6'h0))
                 | evt_next;
    end
  end

  // Read data is latched in the setup phase so the access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= WORD_RST;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        pslverr <= 1'b0;
        prdata  <= WORD_RST;
        if (paddr == OFS_CTRL) begin
          prdata <= 32'(ctrl_reg);
        end else if (paddr == OFS_ZRANGE) begin
          prdata <= 32'(zrange_reg);
        end else if (paddr == OFS_CAPACITY) begin
          prdata <= cap_reg;
        end else if (paddr == OFS_INTERVAL) begin
          prdata <= interval_reg;
        end else if (paddr == OFS_AT_THRESH) begin
          prdata <= at_thresh_reg;
        end else if (paddr == OFS_AT_RESET) begin
          prdata <= at_reset_reg;
        end else if (paddr == OFS_KB_PRESET || paddr == OFS_CMD) begin
          prdata <= WORD_RST;
        end else if (paddr == OFS_INIT_ZERO) begin
          prdata <= init_zero_reg;
        end else if (paddr == OFS_REC_SEL) begin
          prdata <= 32'(rec_sel_reg);
        end else if (paddr == OFS_REC_TARE) begin
          prdata <= sel_ok ? rec_tare[rec_sel_reg] : WORD_RST;
        end else if (paddr >= OFS_REC_DESC && paddr < OFS_REC_TOTAL
                     && paddr[1:0] == 2'b00) begin
          prdata <= sel_ok ? rec_desc[rec_sel_reg][3'(paddr[7:2] - 6'hA)]
                           : WORD_RST;
        end else if (paddr == OFS_REC_TOTAL) begin
          prdata <= sel_ok ? rec_total[rec_sel_reg] : WORD_RST;
        end else if (paddr == OFS_REC_COUNT) begin
          prdata <= sel_ok ? 32'(rec_count[rec_sel_reg]) : WORD_RST;
        end else if (paddr == OFS_STATUS) begin
          prdata <= {27'h0, cur_rec_ok_reg, at_armed,
                     ctrl_reg[CTRL_NSC_EN], state_reg != ST_IDLE, net_mode};
        end else if (paddr == OFS_ERR) begin
          prdata <= 32'(err_reg);
        end else if (paddr == OFS_TARE) begin
          prdata <= tare_reg;
        end else if (paddr == OFS_ZERO_OFS) begin
          prdata <= zero_ofs_reg;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Registered display and indication outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      weight_out <= '0;
      mem_marker <= 1'b0;
      busy       <= 1'b0;
      tare_evt   <= '0;
    end else begin
      weight_out.gross <= disp_gross;
      weight_out.tare  <= disp_tare;
      weight_out.net   <= net_mode ? disp_net : gross;
      mem_marker <= ctrl_reg[CTRL_NSC_EN];
      busy       <= state_reg != ST_IDLE;
      tare_evt   <= evt_next;
    end
  end

  sequence pb_motion_s;
    state_reg == ST_IDLE && !zero_req && tare_req && gross > 32'sh0
      && scale_in.motion;
  endsequence

  sequence timeout_s;
    state_reg == ST_WAIT_PB && scale_in.motion && wait_done;
  endsequence

  pb_tare_take_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && !zero_req && pb_fire
    |=> tare_reg == $past(gross) && net_mode)
    else $error("pushbutton tare not stored");

  pb_disabled_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && !ctrl_reg[CTRL_PB_EN] && !zero_req
    && !preset_req && !at_fire |=> $stable(tare_reg))
    else $error("tare taken while pushbutton tare off");

  too_small_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && !zero_req && tare_req && gross <= 32'sh0
    |=> $stable(tare_reg) ##1 tare_evt.too_small)
    else $error("too small tare not flagged");

  motion_wait_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pb_motion_s |=> state_reg == ST_WAIT_PB && busy == 1'b0
    ##1 busy)
    else $error("motion wait not entered");

  wait_timeout_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    timeout_s |=> state_reg == ST_IDLE && $stable(tare_reg)
    && evt_next.motion_fail)
    else $error("motion timeout not handled");

  wait_bound_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wait_cnt_reg < WAIT_CYC)
    else $error("motion wait overran");

  preset_block_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && !zero_req && !tare_req && preset_req
    && scale_in.over_cap |=> $stable(tare_reg) && evt_next.over_cap)
    else $error("preset accepted over capacity");

  preset_round_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && !zero_req && !tare_req && preset_req
    && !scale_in.over_cap && !scale_in.under_zero && preset_rnd <= cap_reg
    |=> interval_reg == 32'h0 || (tare_reg % interval_reg) == 32'sh0)
    else $error("preset tare not on interval");

  rearm_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(at_armed) |-> $past(gross) < $past(at_reset_reg)
    && $past(at_reset_reg) < $past(at_thresh_reg))
    else $error("auto tare re-armed above reset");

  zero_range_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_reg == ST_IDLE && zero_req && !zero_in_range
    |=> $stable(zero_ofs_reg) ##1 tare_evt.zero_fail)
    else $error("zero accepted outside window");

endmodule

/* sztc_pkg.sv */
package sztc_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MOTION_WAIT_S = 3;
  localparam int unsigned MOTION_WAIT_CYC = MOTION_WAIT_S * CLK_HZ;

  // Byte offsets on the APB register bus
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ZRANGE    = 8'h04;
  localparam logic [7:0] OFS_CAPACITY  = 8'h08;
  localparam logic [7:0] OFS_INTERVAL  = 8'h0C;
  localparam logic [7:0] OFS_AT_THRESH = 8'h10;
  localparam logic [7:0] OFS_AT_RESET  = 8'h14;
  localparam logic [7:0] OFS_KB_PRESET = 8'h18;
  localparam logic [7:0] OFS_INIT_ZERO = 8'h1C;
  localparam logic [7:0] OFS_REC_SEL   = 8'h20;
  localparam logic [7:0] OFS_REC_TARE  = 8'h24;
  localparam logic [7:0] OFS_REC_DESC  = 8'h28;
  localparam logic [7:0] OFS_REC_TOTAL = 8'h3C;
  localparam logic [7:0] OFS_REC_COUNT = 8'h40;
  localparam logic [7:0] OFS_CMD       = 8'h44;
  localparam logic [7:0] OFS_STATUS    = 8'h48;
  localparam logic [7:0] OFS_ERR       = 8'h4C;
  localparam logic [7:0] OFS_TARE      = 8'h50;
  localparam logic [7:0] OFS_ZERO_OFS  = 8'h54;

  // Control register fields
  localparam int CTRL_PB_EN    = 0;
  localparam int CTRL_KB_EN    = 1;
  localparam int CTRL_NSC_EN   = 2;
  localparam int CTRL_AT_EN    = 3;
  localparam int CTRL_AT_MCHK  = 4;
  localparam int CTRL_PUZ_EN   = 5;
  localparam int CTRL_TOT_EN   = 6;
  localparam int CTRL_TOT_NET  = 7;
  localparam int CTRL_W        = 8;

  // Command register bits, self clearing
  localparam int CMD_ZERO   = 0;
  localparam int CMD_TARE   = 1;
  localparam int CMD_RECALL = 2;
  localparam int CMD_TRANS  = 3;

  localparam logic [CTRL_W-1:0] CTRL_RST     = 8'h03;
  localparam logic [6:0]        ZRANGE_RST   = 7'h02;
  localparam logic [31:0]       CAP_RST      = 32'h0000_2710;
  localparam logic [31:0]       INTERVAL_RST = 32'h0000_0001;
  localparam logic [31:0]       WORD_RST     = 32'h0000_0000;
  localparam logic [6:0]        PCT_FULL     = 7'h64;

  localparam int unsigned NUM_REC    = 25;
  localparam int unsigned DESC_WORDS = 5;
  localparam logic [4:0]  REC_LAST   = 5'h18;
  localparam logic [7:0]  ZERO_CHAR  = 8'h5A;

  typedef struct packed {
    logic signed [31:0] raw;
    logic               motion;
    logic               over_cap;
    logic               under_zero;
  } sztc_scale_s;

  typedef struct packed {
    logic signed [31:0] gross;
    logic signed [31:0] tare;
    logic signed [31:0] net;
  } sztc_weight_s;

  typedef struct packed {
    logic motion_fail;
    logic too_small;
    logic over_cap;
    logic out_of_range;
    logic zero_fail;
    logic at_motion_fail;
  } sztc_evt_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_PB, ST_WAIT_AT} sztc_state_e;

endpackage

/* sztc_opr.sv */
module sztc_opr (
  input  wire logic        pclk,
  output logic             zero_key,
  output logic             tare_key,
  output logic             zero_din,
  output logic             plc_zero,
  output logic             plc_tare,
  output logic             plc_preset_valid,
  output logic [31:0]      plc_preset_value,
  output logic             rx_valid,
  output logic [7:0]       rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import sztc_pkg::*;
  initial begin
    {zero_key, tare_key, zero_din, plc_zero, plc_tare} = '0;
    plc_preset_valid = 1'b0;
    plc_preset_value = 32'h0;
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end
  // Pins pass a synchroniser, so they are held for several edges
  task automatic act(input int k);
    @(posedge pclk);
    case (k)
      0: zero_key <= 1'b1;
      1: zero_din <= 1'b1;
      2: plc_zero <= 1'b1;
      3, 6: begin
        rx_valid <= 1'b1;
        rx_data <= (k == 3) ? ZERO_CHAR : ~ZERO_CHAR;
      end
      4: tare_key <= 1'b1;
      default: plc_tare <= 1'b1;
    endcase
    @(posedge pclk);
    {plc_zero, plc_tare, rx_valid} <= '0;
    rx_data <= ~ZERO_CHAR;
    repeat (4) @(posedge pclk);
    {zero_key, tare_key, zero_din} <= '0;
  endtask
  task automatic preset(input logic [31:0] v);
    @(posedge pclk);
    plc_preset_valid <= 1'b1;
    plc_preset_value <= v;
    @(posedge pclk);
    plc_preset_valid <= 1'b0;
    plc_preset_value <= ~v;
  endtask
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sztc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr, rx_data;
  logic [31:0]  pwdata, prdata, rdata, plc_preset_value;
  logic         zero_key, tare_key, zero_din, plc_zero, plc_tare;
  logic         plc_preset_valid, rx_valid, net_mode, mem_marker;
  logic         busy, at_armed, rerr;
  sztc_scale_s  scale_in;
  sztc_weight_s weight_out;
  sztc_evt_s    tare_evt;
  int           err_total, tests_run;
  sztc_core #(.WAIT_CYC(50)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scale_in,
    .zero_key, .tare_key, .zero_din, .plc_zero, .plc_tare,
    .plc_preset_valid, .plc_preset_value, .rx_valid, .rx_data,
    .weight_out, .net_mode, .mem_marker, .busy, .at_armed, .tare_evt);
  sztc_opr opr_u (.pclk, .zero_key, .tare_key, .zero_din, .plc_zero,
    .plc_tare, .plc_preset_valid, .plc_preset_value, .rx_valid, .rx_data);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail();
    err_total++;
    $display("CHECK FAILED t=%0t wait limit", $time);
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  // Error flags are sticky, so clear them after each look
  task automatic ec(input logic [31:0] exp);
    rc(OFS_ERR, exp);
    xfer(1'b1, OFS_ERR, 32'hFFFF_FFFF);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  task automatic sc(input logic [31:0] r, input logic m);
    @(posedge pclk);
    scale_in <= {r, m, 2'b00};
  endtask
  task automatic wc(input logic [31:0] g, t, n);
    settle();
    chk(weight_out.gross, g);
    chk(weight_out.tare, t);
    chk(weight_out.net, n);
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) fail();
  endtask
  task automatic tdone(input string s);
    $display("test %s done, mismatches %0d", s, err_total);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    scale_in = '0;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFS_CTRL, 32'h3);
    rc(OFS_ZRANGE, 32'h2);
    rc(OFS_CAPACITY, 32'h2710);
    rc(OFS_STATUS, 32'h8);
    xfer(1'b0, 8'hF0, 32'h0);
    chk(rerr, 32'h1);
    tdone("registers");
    for (int k = 0; k < 4; k++) begin
      sc(40 * k + 40, 1'b0);
      opr_u.act(k);
      settle();
      rc(OFS_ZERO_OFS, 40 * k + 40);
    end
    sc(200, 1'b0);
    wr(OFS_CMD, 32'h1);
    settle();
    rc(OFS_ZERO_OFS, 32'd200);
    sc(201, 1'b0);
    opr_u.act(2);
    settle();
    rc(OFS_ZERO_OFS, 32'd200);
    ec(32'h2);
    sc(150, 1'b0);
    opr_u.act(6);
    settle();
    rc(OFS_ZERO_OFS, 32'd200);
    wr(OFS_INIT_ZERO, 32'd1000);
    wr(OFS_CTRL, 32'h23);
    sc(1150, 1'b0);
    wr(OFS_CMD, 32'h1);
    settle();
    rc(OFS_ZERO_OFS, 32'd1150);
    sc(200, 1'b0);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CMD, 32'h1);
    settle();
    rc(OFS_ZERO_OFS, 32'd200);
    tdone("zero");
    wr(OFS_CTRL, 32'h2);
    sc(300, 1'b0);
    opr_u.act(4);
    settle();
    rc(OFS_TARE, 32'h0);
    wr(OFS_CTRL, 32'h3);
    sc(200, 1'b0);
    opr_u.act(5);
    settle();
    ec(32'h10);
    sc(300, 1'b0);
    opr_u.act(4);
    wc(100, 100, 0);
    chk(net_mode, 32'h1);
    sc(350, 1'b0);
    wc(150, 100, 50);
    sc(340, 1'b1);
    wr(OFS_CMD, 32'h2);
    repeat (4) @(posedge pclk);
    chk(busy, 32'h1);
    wr(OFS_KB_PRESET, 32'd70);
    sc(340, 1'b0);
    idle_wait();
    rc(OFS_TARE, 32'd140);
    sc(400, 1'b1);
    wr(OFS_CMD, 32'h2);
    repeat (4) @(posedge pclk);
    idle_wait();
    settle();
    rc(OFS_TARE, 32'd140);
    ec(32'h20);
    tdone("pushbutton");
    wr(OFS_INTERVAL, 32'd10);
    wr(OFS_KB_PRESET, 32'd25);
    settle();
    rc(OFS_TARE, 32'd30);
    wr(OFS_KB_PRESET, 32'd24);
    settle();
    rc(OFS_TARE, 32'd20);
    wr(OFS_KB_PRESET, 32'd10005);
    settle();
    ec(32'h4);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_KB_PRESET, 32'd50);
    settle();
    rc(OFS_TARE, 32'd20);
    wr(OFS_CTRL, 32'h3);
    for (int k = 0; k < 2; k++) begin
      scale_in.over_cap <= (k == 0);
      scale_in.under_zero <= (k == 1);
      wr(OFS_KB_PRESET, 32'd50);
      settle();
      ec(k == 0 ? 32'h8 : 32'h10);
    end
    scale_in.under_zero <= 1'b0;
    opr_u.preset(32'd44);
    settle();
    rc(OFS_TARE, 32'd40);
    tdone("preset");
    sc(220, 1'b0);
    wc(20, 40, -20);
    chk(mem_marker, 32'h0);
    wr(OFS_CTRL, 32'h7);
    wc(40, 20, 20);
    chk(mem_marker, 32'h1);
    tdone("sign");
    wr(OFS_REC_SEL, 32'd25);
    rc(OFS_REC_TARE, 32'h0);
    wr(OFS_REC_SEL, 32'd24);
    wr(OFS_REC_TARE, 32'd64);
    wr(OFS_REC_DESC + 8'h10, 32'h4142_4344);
    rc(OFS_REC_DESC + 8'h10, 32'h4142_4344);
    wr(OFS_REC_TOTAL, 32'h0);
    wr(OFS_CMD, 32'h4);
    wr(OFS_CTRL, 32'hC7);
    wr(OFS_CMD, 32'h8);
    settle();
    rc(OFS_TARE, 32'd60);
    rc(OFS_REC_TOTAL, 32'd40);
    rc(OFS_REC_COUNT, 32'h1);
    tdone("records");
    wr(OFS_AT_THRESH, 32'd200);
    wr(OFS_AT_RESET, 32'd100);
    wr(OFS_CTRL, 32'h1B);
    sc(450, 1'b0);
    settle();
    rc(OFS_TARE, 32'd250);
    chk(at_armed, 32'h0);
    sc(250, 1'b1);
    settle();
    chk(at_armed, 32'h0);
    sc(250, 1'b0);
    settle();
    chk(at_armed, 32'h1);
    sc(500, 1'b1);
    repeat (4) @(posedge pclk);
    idle_wait();
    settle();
    ec(32'h1);
    chk(at_armed, 32'h0);
    tdone("auto");
    summarize();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    fail();
  end
endmodule
